// ==== verilog/clie_engine.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - serial mode forces 8-bit; control byte framing
// - continuation bit picks one-data or stream
// - pointer steps by one after data access
// - glyph access hides cursor and blink
// - shift-on-write shifts display on text writes
// - display off keeps text ram intact
// - cursor is underline, entry mode still runs
// - blink alternates, period scales with oscillator
// - cursor shift carries into next line
// - display shift leaves pointer, lines move together
// - selector picks cursor/display, direction left/right
// - bus width bit; serial cannot clear it
// - 4-bit transfers use two strobes, high first
// - line bits select format and mux rate
// - glyph address set loads low six bits
// - text address set loads full pointer
// - line base addresses per display format
// - status gives busy and pointer; busy ignores
// - glyph writes keep low five bits
// - data read steps pointer, reloads latch
// - only address sets and reads touch latch
// - last address set picks read target; home and clear pick text
// - clear fills spaces, homes, forces increment
// - clear busy 165 cycles, others 3
module clie_engine
    import clie_pkg::*;
#(
    parameter int BLINK_CYC = BLINK_OSC_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic e,
    input wire logic reg_select,
    input wire logic host_read,
    input wire logic [7:0] db_in,
    output logic [7:0] db_out,
    output logic [7:0] db_oe,
    input wire logic ser_start,
    input wire logic ser_valid,
    input wire logic [7:0] ser_byte,
    input wire logic ser_rd_req,
    output logic [7:0] ser_rd_data,
    output logic ser_rd_valid,
    output logic busy_flag,
    output logic [6:0] ram_pointer,
    output logic disp_on,
    output logic cursor_on,
    output logic blink_on,
    output logic blink_phase,
    output logic [5:0] disp_shift,
    output logic [1:0] line_mode,
    output logic mux_32
);
    // ************************************************************
    // state
    // ************************************************************
    logic [6:0] ptr_q, ptr_d;
    logic id_q, id_d, s_q, s_d, d_q, d_d, c_q, c_d, b_q, b_d;
    logic dl_q, dl_d, n_q, n_d, m_q, m_d, glyph_q, glyph_d;
    logic [5:0] shift_q, shift_d;
    logic [7:0] busy_q, busy_d;
    logic clr_q, clr_d;
    logic [6:0] fill_q;
    logic reload_q, reload_d, reload2_q;
    logic [7:0] latch_q;
    logic ser_sel_q;
    logic [31:0] blink_cnt_q;
    logic blink_q;

    // ************************************************************
    // register bus slave, zero wait states
    // ************************************************************
    logic ahb_go, cfg_wr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    assign ahb_go = hsel & hready & (htrans == HTRANS_NONSEQ) & ce;
    assign status_word = {14'h0, ser_sel_q, n_q, m_q, dl_q, b_q, c_q, d_q, s_q, id_q,
                          glyph_q, busy_flag, ptr_q};
    assign rd_mux = (haddr[7:0] == CFG_OFS) ? {31'h0, ser_sel_q} :
                    (haddr[7:0] == STATUS_OFS) ? status_word :
                    (haddr[7:0] == SHIFT_OFS) ? {26'h0, shift_q} : 32'h0;
    assign hrdata = hrdata_q;
    assign hreadyout = ce;
    assign hresp = 1'b0;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_wr_q <= 1'b0;
            hrdata_q <= 32'h0;
            ser_sel_q <= 1'b0;
        end
        else if (ce)
        begin
            cfg_wr_q <= ahb_go & hwrite & (haddr[7:0] == CFG_OFS);
            hrdata_q <= (ahb_go & ~hwrite) ? rd_mux : 32'h0;
            if (cfg_wr_q)
            begin
                ser_sel_q <= hwdata[CFG_SER_BIT];
            end
        end
    end

    // ************************************************************
    // parallel port: strobe sampling and nibble pairing
    // ************************************************************
    logic e_q, nib_q, cap_rs_q, cap_rd_q, par_fall, par_go;
    logic [7:0] cap_db_q;
    logic [3:0] hi_q;
    logic [7:0] rd_byte, par_byte;
    assign par_fall = e_q & ~e & ~ser_sel_q;
    assign par_go = par_fall & (dl_q | nib_q);
    assign par_byte = dl_q ? cap_db_q : {hi_q, cap_db_q[7:4]};
    assign rd_byte = reg_select ? latch_q : {busy_flag, ptr_q};

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            e_q <= 1'b0;
            nib_q <= 1'b0;
            hi_q <= 4'h0;
            cap_db_q <= 8'h0;
            cap_rs_q <= 1'b0;
            cap_rd_q <= 1'b0;
            db_out <= 8'h0;
            db_oe <= 8'h0;
        end
        else if (ce)
        begin
            e_q <= e;
            if (e)
            begin
                cap_db_q <= db_in;
                cap_rs_q <= reg_select;
                cap_rd_q <= host_read;
            end
            if (par_fall & ~dl_q)
            begin
                nib_q <= ~nib_q;
                hi_q <= cap_db_q[7:4];
            end
            // lower lanes stay undriven in 4-bit mode, the pull-ups own them
            db_oe <= (e & host_read & ~ser_sel_q) ? (dl_q ? LANES_ALL : LANES_HI) : 8'h0;
            db_out <= dl_q ? rd_byte :
                      (nib_q ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0});
        end
    end

    // ************************************************************
    // serial framing of control and data bytes
    // ************************************************************
    clie_frame_t frame_q;
    logic ser_rs_q, ser_rd_q, ser_in, ser_data, ser_go;
    assign ser_in = ser_valid & ser_sel_q;
    assign ser_data = ser_in & (frame_q != FR_CTRL);
    assign ser_go = ser_data | (ser_rd_req & ser_sel_q & ser_rd_q);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            frame_q <= FR_CTRL;
            ser_rs_q <= 1'b0;
            ser_rd_q <= 1'b0;
            ser_rd_data <= 8'h0;
            ser_rd_valid <= 1'b0;
        end
        else if (ce)
        begin
            ser_rd_valid <= ser_rd_req & ser_sel_q & ser_rd_q;
            if (ser_rd_req & ser_sel_q & ser_rd_q)
            begin
                ser_rd_data <= ser_rs_q ? latch_q : {busy_flag, ptr_q};
            end
            if (ser_start)
            begin
                frame_q <= FR_CTRL;
            end
            else if (ser_in)
            begin
                unique case (frame_q)
                    FR_CTRL:
                    begin
                        ser_rs_q <= ser_byte[6];
                        ser_rd_q <= ser_byte[5];
                        frame_q <= ser_byte[7] ? FR_ONE : FR_STREAM;
                    end
                    FR_ONE: frame_q <= FR_CTRL;
                    FR_STREAM: frame_q <= FR_STREAM;
                    default: frame_q <= FR_CTRL;
                endcase
            end
        end
    end

    // ************************************************************
    // command merge and decode
    // ************************************************************
    logic cmd_go, cmd_rs, cmd_rd, cmd_ser, busy, go_exec;
    logic [7:0] cmd_b;
    logic is_clear, is_home, is_entry, is_disp, is_shift, is_func, is_gaddr, is_taddr;
    assign cmd_go = par_go | ser_go;
    assign cmd_ser = ser_go;
    assign cmd_rs = ser_go ? ser_rs_q : cap_rs_q;
    assign cmd_rd = ser_go ? ser_rd_q : cap_rd_q;
    assign cmd_b = ser_go ? ser_byte : par_byte;
    assign busy = (busy_q != 8'h0);
    // status reads and no-ops never start execution
    assign go_exec = cmd_go & ~busy & (cmd_rs | ~cmd_rd) & (cmd_rs | (cmd_b != 8'h0));
    assign is_taddr = cmd_b[7];
    assign is_gaddr = (cmd_b[7:6] == 2'h1);
    assign is_func = (cmd_b[7:5] == 3'h1);
    assign is_shift = (cmd_b[7:4] == 4'h1);
    assign is_disp = (cmd_b[7:3] == 5'h01);
    assign is_entry = (cmd_b[7:2] == 6'h01);
    assign is_home = (cmd_b[7:1] == 7'h01);
    assign is_clear = (cmd_b == 8'h01);

    // ************************************************************
    // pointer and shift arithmetic
    // ************************************************************
    logic [6:0] ptr_auto, ptr_right, ptr_left;
    logic [5:0] len, shift_l, shift_r, shift_w;
    assign ptr_auto = id_q ? ptr_q + 7'h01 : ptr_q - 7'h01;
    // line bases 00/40 for two lines, 00/20/40/60 for four
    assign ptr_right = m_q ?
        ((ptr_q[4:0] == LAST_COL_4L) ? {ptr_q[6:5] + 2'h1, 5'h0} : ptr_q + 7'h01) :
        ((ptr_q[5:0] == LAST_COL_2L) ? {~ptr_q[6], 6'h0} : ptr_q + 7'h01);
    assign ptr_left = m_q ?
        ((ptr_q[4:0] == 5'h0) ? {ptr_q[6:5] - 2'h1, LAST_COL_4L} : ptr_q - 7'h01) :
        ((ptr_q[5:0] == 6'h0) ? {~ptr_q[6], LAST_COL_2L} : ptr_q - 7'h01);
    // one offset for all lines, so nothing spills into a neighbour line
    assign len = m_q ? LINE_LEN_4L : LINE_LEN_2L;
    assign shift_l = (shift_q >= len - 6'h1) ? 6'h0 : shift_q + 6'h1;
    assign shift_r = (shift_q == 6'h0) ? len - 6'h1 : shift_q - 6'h1;
    assign shift_w = id_q ? shift_l : shift_r;

    // ************************************************************
    // instruction execution
    // ************************************************************
    always_comb
    begin
        ptr_d = ptr_q;
        {id_d, s_d, d_d, c_d, b_d} = {id_q, s_q, d_q, c_q, b_q};
        {dl_d, n_d, m_d, glyph_d} = {dl_q, n_q, m_q, glyph_q};
        shift_d = shift_q;
        busy_d = busy ? busy_q - 8'h01 : busy_q;
        clr_d = clr_q & (fill_q != FILL_LAST);
        reload_d = 1'b0;
        if (go_exec)
        begin
            busy_d = EXEC_CYC;
            if (cmd_rs)
            begin
                ptr_d = ptr_auto;
                reload_d = cmd_rd;
                if (~cmd_rd & ~glyph_q & s_q)
                begin
                    shift_d = shift_w;
                end
            end
            else if (is_taddr)
            begin
                ptr_d = cmd_b[6:0];
                glyph_d = 1'b0;
                reload_d = 1'b1;
            end
            else if (is_gaddr)
            begin
                ptr_d = {ptr_q[6], cmd_b[5:0]};
                glyph_d = 1'b1;
                reload_d = 1'b1;
            end
            else if (is_func)
            begin
                dl_d = cmd_ser ? 1'b1 : cmd_b[4];
                n_d = cmd_b[3];
                m_d = cmd_b[2];
            end
            else if (is_shift)
            begin
                if (cmd_b[3])
                begin
                    shift_d = cmd_b[2] ? shift_r : shift_l;
                end
                else
                begin
                    ptr_d = cmd_b[2] ? ptr_right : ptr_left;
                end
            end
            else if (is_disp)
            begin
                {d_d, c_d, b_d} = cmd_b[2:0];
            end
            else if (is_entry)
            begin
                {id_d, s_d} = cmd_b[1:0];
            end
            else if (is_home | is_clear)
            begin
                ptr_d = 7'h0;
                shift_d = 6'h0;
                glyph_d = 1'b0;
                if (is_clear)
                begin
                    id_d = 1'b1;
                    clr_d = 1'b1;
                    busy_d = CLEAR_CYC;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ptr_q <= 7'h0;
            {id_q, s_q, d_q, c_q, b_q} <= 5'h10;
            {dl_q, n_q, m_q, glyph_q} <= 4'h8;
            shift_q <= 6'h0;
            busy_q <= 8'h0;
            clr_q <= 1'b0;
            fill_q <= 7'h0;
            reload_q <= 1'b0;
            reload2_q <= 1'b0;
        end
        else if (ce)
        begin
            ptr_q <= ptr_d;
            {id_q, s_q, d_q, c_q, b_q} <= {id_d, s_d, d_d, c_d, b_d};
            {dl_q, n_q, m_q, glyph_q} <= {dl_d, n_d, m_d, glyph_d};
            shift_q <= shift_d;
            busy_q <= busy_d;
            clr_q <= clr_d;
            fill_q <= clr_q ? fill_q + 7'h01 : 7'h0;
            reload_q <= reload_d;
            reload2_q <= reload_q;
        end
    end

    // ************************************************************
    // text and glyph memories, read prefetch latch
    // ************************************************************
    logic wr_data, text_we, glyph_we;
    logic [7:0] text_rd;
    logic [4:0] glyph_rd;
    assign wr_data = go_exec & cmd_rs & ~cmd_rd;
    assign text_we = (wr_data & ~glyph_q) | clr_q;
    assign glyph_we = wr_data & glyph_q;

    clie_ram #(.AW(TEXT_AW), .DW(TEXT_DW)) u_text_ram (
        .ref_clk(ref_clk),
        .ce(ce),
        .we(text_we),
        .addr(clr_q ? fill_q : ptr_q),
        .wdata(clr_q ? TEXT_FILL : cmd_b),
        .rdata(text_rd)
    );

    clie_ram #(.AW(GLYPH_AW), .DW(GLYPH_DW)) u_glyph_ram (
        .ref_clk(ref_clk),
        .ce(ce),
        .we(glyph_we),
        .addr(ptr_q[5:0]),
        .wdata(cmd_b[4:0]),
        .rdata(glyph_rd)
    );

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            latch_q <= 8'h0;
        end
        else if (ce & reload2_q)
        begin
            latch_q <= glyph_q ? {3'h0, glyph_rd} : text_rd;
        end
    end

    // ************************************************************
    // display state outputs and blink timer
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            blink_cnt_q <= 32'h0;
            blink_q <= 1'b0;
        end
        else if (ce)
        begin
            // half period per phase; ref_clk stands in for the oscillator
            if (blink_cnt_q >= 32'(BLINK_CYC / 2 - 1))
            begin
                blink_cnt_q <= 32'h0;
                blink_q <= ~blink_q;
            end
            else
            begin
                blink_cnt_q <= blink_cnt_q + 32'h1;
            end
        end
    end

    assign busy_flag = busy;
    assign ram_pointer = ptr_q;
    assign disp_on = d_q;
    assign cursor_on = d_q & c_q & ~glyph_q;
    assign blink_on = d_q & b_q & ~glyph_q;
    assign blink_phase = blink_q;
    assign disp_shift = shift_q;
    assign line_mode = {m_q, n_q};
    assign mux_32 = n_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !ce);

    sequence s_clear_go;
        go_exec && !cmd_rs && is_clear;
    endsequence
    sequence s_busy_clear;
        busy_flag [*8] ##157 busy_flag ##1 !busy_flag;
    endsequence

    a_ptr_step_data: assert property (go_exec && cmd_rs |=>
        ptr_q == ($past(id_q) ? $past(ptr_q) + 7'h01 : $past(ptr_q) - 7'h01))
        else $error("pointer did not step after data access");
    a_glyph_hides_cursor: assert property (glyph_q |-> !cursor_on && !blink_on)
        else $error("cursor shown during glyph access");
    a_shift_on_write: assert property (wr_data && (glyph_q || !s_q) |=>
        $stable(shift_q))
        else $error("display shifted without text write shift");
    a_clear_busy_time: assert property (s_clear_go |=> s_busy_clear)
        else $error("clear busy time wrong");
    a_busy_ignores_cmd: assert property (busy && cmd_go |=> $stable(ptr_q))
        else $error("instruction executed while busy");
    a_latch_on_write: assert property (wr_data |=> $stable(latch_q) [*3])
        else $error("latch changed by a write");
    a_glyph_addr_set: assert property (go_exec && !cmd_rs && !is_taddr && is_gaddr |=>
        ptr_q == {$past(ptr_q[6]), $past(cmd_b[5:0])})
        else $error("glyph address set wrong");
    a_clear_state: assert property (s_clear_go |=>
        ptr_q == 7'h0 && shift_q == 6'h0 && id_q && s_q == $past(s_q))
        else $error("clear did not home state");
    a_serial_width: assert property (ser_go && go_exec && !cmd_rs && is_func |=> dl_q)
        else $error("serial cleared bus width");
    a_short_busy: assert property (go_exec && !(!cmd_rs && is_clear) |=>
        busy_flag [*3] ##1 !busy_flag)
        else $error("instruction busy time wrong");
endmodule // clie_engine

// ==== verilog/clie_pkg.sv ====
package clie_pkg;

    // ************************************************************
    // register bus map
    // ************************************************************
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] SHIFT_OFS = 8'h08;
    localparam int CFG_SER_BIT = 0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // ************************************************************
    // execution timing, in oscillator cycles
    // ************************************************************
    localparam logic [7:0] EXEC_CYC = 8'h03;
    localparam logic [7:0] CLEAR_CYC = 8'ha5;
    localparam int BLINK_PERIOD_MS = 1000;
    localparam int NOM_OSC_KHZ = 150;
    localparam int BLINK_OSC_CYC = BLINK_PERIOD_MS * NOM_OSC_KHZ;

    // ************************************************************
    // memories and contents
    // ************************************************************
    localparam int TEXT_AW = 7;
    localparam int TEXT_DW = 8;
    localparam int GLYPH_AW = 6;
    localparam int GLYPH_DW = 5;
    localparam logic [7:0] TEXT_FILL = 8'h20;
    localparam logic [6:0] FILL_LAST = 7'h7f;

    // ************************************************************
    // line geometry
    // ************************************************************
    localparam logic [5:0] LAST_COL_2L = 6'h27;
    localparam logic [4:0] LAST_COL_4L = 5'h13;
    localparam logic [5:0] LINE_LEN_2L = 6'h28;
    localparam logic [5:0] LINE_LEN_4L = 6'h14;

    // ************************************************************
    // parallel port lanes
    // ************************************************************
    localparam logic [7:0] LANES_ALL = 8'hff;
    localparam logic [7:0] LANES_HI = 8'hf0;

    // serial framing, gray along ctrl -> one -> stream
    typedef enum logic [1:0] {
        FR_CTRL = 2'h0,
        FR_ONE = 2'h1,
        FR_STREAM = 2'h3
    } clie_frame_t;

endpackage

// ==== verilog/clie_ram.sv ====
`timescale 1ns/1ps
module clie_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic ref_clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    // ************************************************************
    // storage, registered read
    // ************************************************************
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge ref_clk)
    begin
        if (ce)
        begin
            if (we)
            begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule // clie_ram

// ==== sim/clie_host.sv ====
`timescale 1ns/1ps
// ********
// host microcontroller model
// ********
module clie_host (
    input wire logic ref_clk,
    input wire logic busy_flag,
    input wire logic [7:0] db_out,
    input wire logic [7:0] db_oe,
    input wire logic [7:0] ser_rd_data,
    input wire logic ser_rd_valid,
    output logic e,
    output logic reg_select,
    output logic host_read,
    output logic [7:0] db_in,
    output logic ser_start,
    output logic ser_valid,
    output logic [7:0] ser_byte,
    output logic ser_rd_req
);
    logic wide = 1'b1;
    int busy_n;
    logic [7:0] oe_seen;
    initial {e, reg_select, host_read, ser_start, ser_valid, ser_rd_req} = 6'h00;
    initial db_in = 8'hff;
    initial ser_byte = 8'h00;
    // poll until idle; anything sent while busy would be dropped
    task wait_busy;
        busy_n = 0;
        @(posedge ref_clk);
        #1;
        while (busy_flag === 1'b1)
        begin
            busy_n++;
            @(posedge ref_clk);
            #1;
        end
    endtask
    task strobe(input logic rs, input logic rd, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        e <= 1'b1;
        reg_select <= rs;
        host_read <= rd;
        db_in <= rd ? 8'hff : d;
        @(posedge ref_clk);
        #1;
        q = db_out;
        oe_seen = db_oe;
        @(posedge ref_clk);
        e <= 1'b0;
        db_in <= 8'hff;
    endtask
    task par(input logic rs, input logic rd, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] t;
        if (wide)
            strobe(rs, rd, d, q);
        else
        begin
            // high nibble first, low lanes left to the pull-ups
            strobe(rs, rd, {d[7:4], 4'hf}, t);
            strobe(rs, rd, {d[3:0], 4'hf}, q);
            q = {t[7:4], q[7:4]};
        end
        if (rs || !rd)
            wait_busy;
    endtask
    // new frame restarts with a control byte
    task ser(input logic st, input logic [7:0] b);
        if (st)
        begin
            @(posedge ref_clk);
            ser_start <= 1'b1;
            @(posedge ref_clk);
            ser_start <= 1'b0;
        end
        @(posedge ref_clk);
        ser_valid <= 1'b1;
        ser_byte <= b;
        @(posedge ref_clk);
        ser_valid <= 1'b0;
        ser_byte <= ~b;
    endtask
    task ser_read(output logic [7:0] q);
        @(posedge ref_clk);
        ser_rd_req <= 1'b1;
        @(posedge ref_clk);
        ser_rd_req <= 1'b0;
        #1;
        while (ser_rd_valid !== 1'b1)
        begin
            @(posedge ref_clk);
            #1;
        end
        q = ser_rd_data;
    endtask
endmodule // clie_host

// ==== sim/tb.sv ====
`timescale 1ns/1ps
// ********
// testbench top
// ********
module tb;
    import clie_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, line_mode;
    logic hreadyout, hresp, e, reg_select, host_read, ser_start, ser_valid, ser_rd_req;
    logic ser_rd_valid, busy_flag, disp_on, cursor_on, blink_on, blink_phase, mux_32;
    logic [7:0] db_in, db_out, db_oe, ser_byte, ser_rd_data, q;
    logic [6:0] ram_pointer;
    logic [5:0] disp_shift;
    int num_errors = 0, n_compared = 0, cycles = 0;
    initial forever #20 ref_clk = ~ref_clk;
    // short blink period keeps the run small
    clie_engine #(.BLINK_CYC(8)) clie_engine_i (.*, .hready(hreadyout), .hsize(3'h2));
    clie_host clie_host_i (.*);
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // k is {reg_select, host_read}; pointer checked after every access
    task op(input logic [1:0] k, input logic [7:0] d, input logic [6:0] p);
        clie_host_i.par(k[1], k[0], d, q);
        chk("pointer", {25'h0, p}, {25'h0, ram_pointer});
    endtask
    task summarize;
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // whole sequence needs a few hundred cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            summarize;
        end
    end
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        chk("status", 32'h4200, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        ahb(1'b0, 8'h0c, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        op(2'b00, 8'h85, 7'h05);
        chk("busy_n", 32'd3, clie_host_i.busy_n);
        clie_host_i.strobe(1'b0, 1'b0, 8'h85, q);
        clie_host_i.strobe(1'b0, 1'b0, 8'h80, q);
        clie_host_i.wait_busy;
        chk("pointer", 32'h5, {25'h0, ram_pointer});
        op(2'b10, 8'h41, 7'h06);
        op(2'b00, 8'h04, 7'h06);
        op(2'b10, 8'h42, 7'h05);
        op(2'b00, 8'h05, 7'h05);
        op(2'b10, 8'h43, 7'h04);
        chk("shift", 32'h27, {26'h0, disp_shift});
        op(2'b00, 8'h14, 7'h05);
        op(2'b00, 8'h1c, 7'h05);
        chk("shift", 32'h26, {26'h0, disp_shift});
        op(2'b00, 8'h86, 7'h06);
        op(2'b11, 8'h00, 7'h05);
        chk("data", 32'h42, {24'h0, q});
        chk("db_oe", 32'hff, {24'h0, clie_host_i.oe_seen});
        op(2'b11, 8'h00, 7'h04);
        chk("data", 32'h43, {24'h0, q});
        op(2'b00, 8'h86, 7'h06);
        op(2'b10, 8'h44, 7'h05);
        op(2'b11, 8'h00, 7'h04);
        chk("data", 32'h42, {24'h0, q});
        op(2'b00, 8'h0f, 7'h04);
        chk("cursor", 32'h3, {30'h0, cursor_on, blink_on});
        q[0] = blink_phase;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("blink", {31'h0, ~q[0]}, {31'h0, blink_phase});
        op(2'b00, 8'hc5, 7'h45);
        op(2'b00, 8'h7f, 7'h7f);
        chk("cursor", 32'h0, {30'h0, cursor_on, blink_on});
        op(2'b10, 8'hff, 7'h7e);
        op(2'b00, 8'h7f, 7'h7f);
        op(2'b11, 8'h00, 7'h7e);
        chk("data", 32'h1f, {24'h0, q});
        op(2'b00, 8'h08, 7'h7e);
        chk("disp_on", 32'h0, {31'h0, disp_on});
        op(2'b00, 8'h86, 7'h06);
        op(2'b11, 8'h00, 7'h05);
        chk("data", 32'h44, {24'h0, q});
        op(2'b00, 8'h0c, 7'h05);
        op(2'b00, 8'h80, 7'h00);
        op(2'b11, 8'h00, 7'h7f);
        op(2'b00, 8'h20, 7'h7f);
        clie_host_i.wide = 1'b0;
        op(2'b00, 8'h2c, 7'h7f);
        chk("lines", 32'h7, {29'h0, line_mode, mux_32});
        op(2'b01, 8'h00, 7'h7f);
        chk("status", 32'h7f, {24'h0, q});
        chk("db_oe", 32'hf0, {24'h0, clie_host_i.oe_seen});
        op(2'b00, 8'h02, 7'h00);
        chk("shift", 32'h0, {26'h0, disp_shift});
        op(2'b00, 8'h01, 7'h00);
        chk("busy_n", 32'd165, clie_host_i.busy_n);
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        chk("status", 32'h18e00, rd);
        ahb(1'b1, CFG_OFS, 32'h1, rd);
        clie_host_i.ser(1'b1, 8'h80);
        clie_host_i.ser(1'b0, 8'h2c);
        clie_host_i.wait_busy;
        clie_host_i.ser(1'b0, 8'h00);
        clie_host_i.ser(1'b0, 8'h85);
        clie_host_i.wait_busy;
        clie_host_i.ser(1'b1, 8'h60);
        clie_host_i.ser_read(q);
        chk("data", 32'h20, {24'h0, q});
        clie_host_i.wait_busy;
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        chk("status", 32'h3ce06, rd);
        summarize;
    end
endmodule // tb
